/* File: core/piu_pkg.sv */
/*
 * Constants for the prioritized interrupt unit: register map, flag
 * layout, priority levels and vectors.
 * Assumes an APB master on pclk and synchronous event pulses from the
 * on-chip peripherals; pin inputs are asynchronous.
 */
package piu_pkg;
	localparam int NSRC = 11;
	localparam int NFLAG = 18;
	localparam int NLVL = 6;
	// Flag bit positions
	localparam int F_NMI = 0;
	localparam int F_T0 = 1;
	localparam int F_T1 = 2;
	localparam int F_RISE = 3;
	localparam int F_FALL = 4;
	localparam int F_E0 = 5;
	localparam int F_E1 = 6;
	localparam int F_CIN = 7;
	localparam int F_AD = 8;
	localparam int F_SR = 9;
	localparam int F_ST = 10;
	localparam int F_ER = 11;
	localparam int F_OV = 12;
	localparam int F_AN = 13;
	localparam int F_SB = 17;
	// Register byte offsets
	localparam logic [7:0] A_FLAG = 8'h00;
	localparam logic [7:0] A_MASK = 8'h04;
	localparam logic [7:0] A_VEC = 8'h08;
	localparam logic [7:0] A_ISTAT = 8'h0c;
	localparam logic [7:0] A_IMASK = 8'h10;
	localparam logic [7:0] A_CTRL = 8'h14;
	localparam logic [10:0] MASK_RST = 11'h7fe;
	localparam logic [7:0] VEC_NONE = 8'h00;
	// Vector per level
	localparam logic [7:0] VEC_L0 = 8'h04;
	localparam logic [7:0] VEC_L1 = 8'h08;
	localparam logic [7:0] VEC_L2 = 8'h10;
	localparam logic [7:0] VEC_L3 = 8'h18;
	localparam logic [7:0] VEC_L4 = 8'h20;
	localparam logic [7:0] VEC_L5 = 8'h28;
	localparam logic [2:0] LVL_NONE = 3'h7;
	typedef enum logic [1:0] {ST_IDLE, ST_ACK} piu_state_type;
endpackage

/* File: core/piu_core.sv */
/*
 * Prioritized interrupt unit with APB register access.
 * Assumes peripheral event inputs are one-cycle pulses on pclk; pins
 * (nmi, rising, falling, analog) are asynchronous and synchronised here.
 * The CPU takes a request with int_ack, which clears the flag only when the nmi (level 0) is served.
 */
module piu_core (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic nmi_n_pin,
	input wire logic rising_edge_request,
	input wire logic falling_edge_request,
	input wire logic [3:0] upper_analog_pin,
	input wire logic timer0_match,
	input wire logic timer1_match,
	input wire logic event_counter_match0,
	input wire logic event_counter_match1,
	input wire logic counter_input_fall,
	input wire logic conversion_done,
	input wire logic serial_rx_done,
	input wire logic serial_tx_done,
	input wire logic serial_error,
	input wire logic timer_overflow,
	input wire logic standby_entry,
	input wire logic int_ack,
	output logic int_req,
	output logic [7:0] int_vector,
	output logic [2:0] int_level,
	output logic irq
);
	import piu_pkg::*;

	typedef struct packed {
		logic [6:0] s1;
		logic [6:0] s2;
		logic [6:0] prev;
		logic [NFLAG-1:0] flag;
		logic [10:0] mask;
		logic enable;
		logic [1:0] istat;
		logic [1:0] imask;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic int_req;
		logic [7:0] vec;
		logic [2:0] lvl;
		logic irq;
		piu_state_type st;
	} piu_regs_type;

	piu_regs_type r_ff, nxt_r;

	function automatic logic [7:0] lvl_vec(input logic [2:0] l);
		case (l)
			3'd0: lvl_vec = VEC_L0;
			3'd1: lvl_vec = VEC_L1;
			3'd2: lvl_vec = VEC_L2;
			3'd3: lvl_vec = VEC_L3;
			3'd4: lvl_vec = VEC_L4;
			3'd5: lvl_vec = VEC_L5;
			default: lvl_vec = VEC_NONE;
		endcase
	endfunction

	logic [6:0] pins;
	logic [6:0] fall_ev;
	logic rise_ev;
	logic [NLVL-1:0] lvl_pend;
	logic [2:0] win;
	logic [NFLAG-1:0] set_v;
	logic [NFLAG-1:0] clr_v;
	logic wr;
	logic rd;
	logic ack_ev;

	// Pins: nmi, rising, falling, four analog lines
	assign pins = {upper_analog_pin, falling_edge_request,
		rising_edge_request, nmi_n_pin};
	// Zero-cross pins arrive already squared; same edge logic serves
	// both AC-coupled and directly driven use
	assign rise_ev = r_ff.s2[1] & ~r_ff.prev[1];
	assign fall_ev = ~r_ff.s2 & r_ff.prev;

	always_comb begin
		set_v = '0;
		set_v[F_NMI] = fall_ev[0];
		set_v[F_T0] = timer0_match;
		set_v[F_T1] = timer1_match;
		set_v[F_RISE] = rise_ev;
		set_v[F_FALL] = fall_ev[2];
		set_v[F_E0] = event_counter_match0;
		set_v[F_E1] = event_counter_match1;
		set_v[F_CIN] = counter_input_fall;
		set_v[F_AD] = conversion_done;
		set_v[F_SR] = serial_rx_done;
		set_v[F_ST] = serial_tx_done;
		set_v[F_ER] = serial_error;
		set_v[F_OV] = timer_overflow;
		set_v[F_AN+:4] = fall_ev[6:3];
		set_v[F_SB] = standby_entry;
	end

	// Level grouping, nmi unmaskable
	always_comb begin
		lvl_pend[0] = r_ff.flag[F_NMI];
		lvl_pend[1] = |(r_ff.flag[F_T1:F_T0] & ~r_ff.mask[F_T1:F_T0]);
		lvl_pend[2] = |(r_ff.flag[F_FALL:F_RISE] & ~r_ff.mask[F_FALL:F_RISE]);
		lvl_pend[3] = |(r_ff.flag[F_E1:F_E0] & ~r_ff.mask[F_E1:F_E0]);
		lvl_pend[4] = |(r_ff.flag[F_AD:F_CIN] & ~r_ff.mask[F_AD:F_CIN]);
		lvl_pend[5] = |(r_ff.flag[F_ST:F_SR] & ~r_ff.mask[F_ST:F_SR]);
		if (!r_ff.enable) begin
			lvl_pend[NLVL-1:1] = '0;
		end
		win = LVL_NONE;
		for (int i = NLVL - 1; i >= 0; i--) begin
			if (lvl_pend[i]) begin
				win = 3'(i);
			end
		end
	end

	assign wr = psel & penable & pwrite;
	assign rd = psel & penable & ~pwrite;
	assign ack_ev = int_ack & r_ff.int_req & (r_ff.st == ST_IDLE);

	always_comb begin
		nxt_r = r_ff;
		nxt_r.s1 = pins;
		nxt_r.s2 = r_ff.s1;
		nxt_r.prev = r_ff.s2;
		clr_v = '0;
		// Served source clears; for a shared level software tells them
		// apart from the flags, so clear only the nmi latch here
		if (ack_ev && r_ff.lvl == 3'd0) begin
			clr_v[F_NMI] = 1'b1;
		end
		if (wr && paddr == A_FLAG) begin
			clr_v = clr_v | pwdata[NFLAG-1:0];
		end
		// Set wins over clear
		nxt_r.flag = (r_ff.flag & ~clr_v) | set_v;
		nxt_r.pready = psel & ~penable;
		nxt_r.pslverr = 1'b0;
		nxt_r.prdata = '0;
		if (psel && !penable) begin
			case (paddr)
				A_FLAG: nxt_r.prdata = 32'(r_ff.flag);
				A_MASK: nxt_r.prdata = 32'(r_ff.mask);
				A_VEC: nxt_r.prdata = {21'h0, r_ff.lvl, r_ff.vec};
				A_ISTAT: nxt_r.prdata = 32'(r_ff.istat);
				A_IMASK: nxt_r.prdata = 32'(r_ff.imask);
				A_CTRL: nxt_r.prdata = 32'(r_ff.enable);
				default: nxt_r.pslverr = 1'b1;
			endcase
		end
		if (wr) begin
			case (paddr)
				A_MASK: nxt_r.mask = pwdata[NSRC-1:0];
				A_IMASK: nxt_r.imask = pwdata[1:0];
				A_CTRL: nxt_r.enable = pwdata[0];
				default: ;
			endcase
		end
		// Status: 0 request raised, 1 request acknowledged
		nxt_r.istat = r_ff.istat & ~((wr && paddr == A_ISTAT) ?
			pwdata[1:0] : 2'b00);
		nxt_r.istat[0] = nxt_r.istat[0] | (win != LVL_NONE & !r_ff.int_req);
		nxt_r.istat[1] = nxt_r.istat[1] | ack_ev;
		nxt_r.irq = |(nxt_r.istat & ~nxt_r.imask);
		case (r_ff.st)
			ST_IDLE: begin
				nxt_r.int_req = (win != LVL_NONE);
				nxt_r.lvl = win;
				nxt_r.vec = lvl_vec(win);
				if (ack_ev) begin
					nxt_r.int_req = 1'b0;
					nxt_r.st = ST_ACK;
				end
			end
			ST_ACK: begin
				// At least one dead cycle, held until int_ack drops, lets the nmi clear settle
				nxt_r.int_req = 1'b0;
				if (!int_ack) begin
					nxt_r.st = ST_IDLE;
				end
			end
			default: nxt_r.st = ST_IDLE;
		endcase
		if (rd) begin
			nxt_r.pready = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_ff <= '{s1: 7'h7f, s2: 7'h7f, prev: 7'h7f, flag: '0,
				mask: MASK_RST, enable: 1'b0, istat: 2'b00, imask: 2'b11,
				prdata: '0, pready: 1'b0, pslverr: 1'b0, int_req: 1'b0,
				vec: VEC_NONE, lvl: LVL_NONE, irq: 1'b0, st: ST_IDLE};
		end else begin
			r_ff <= nxt_r;
		end
	end

	assign prdata = r_ff.prdata;
	assign pready = r_ff.pready;
	assign pslverr = r_ff.pslverr;
	assign int_req = r_ff.int_req;
	assign int_vector = r_ff.vec;
	assign int_level = r_ff.lvl;
	assign irq = r_ff.irq;

	// Flags hold their set across a simultaneous clear
	a_flag_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
		timer0_match |=> r_ff.flag[F_T0])
		else $error("timer0 flag lost");
	a_nmi_edge_flag: assert property (@(posedge pclk) disable iff (!presetn)
		(!r_ff.s2[0] && r_ff.prev[0]) |=> r_ff.flag[F_NMI])
		else $error("nmi edge not flagged");
	a_rise_edge_flag: assert property (@(posedge pclk) disable iff (!presetn)
		(r_ff.s2[1] && !r_ff.prev[1]) |=> r_ff.flag[F_RISE])
		else $error("rising edge not flagged");
	a_fall_edge_flag: assert property (@(posedge pclk) disable iff (!presetn)
		(!r_ff.s2[2] && r_ff.prev[2]) |=> r_ff.flag[F_FALL])
		else $error("falling edge not flagged");
	a_analog_edge: assert property (@(posedge pclk) disable iff (!presetn)
		(!r_ff.s2[3] && r_ff.prev[3]) |=> r_ff.flag[F_AN])
		else $error("analog edge not flagged");
	a_nmi_top_prio: assert property (@(posedge pclk) disable iff (!presetn)
		(r_ff.flag[F_NMI] && r_ff.st == ST_IDLE && !ack_ev)
		|=> int_level == 3'd0)
		else $error("nmi not highest");
	a_vec_match: assert property (@(posedge pclk) disable iff (!presetn)
		int_req |-> int_vector == lvl_vec(int_level))
		else $error("vector mismatch");
	a_serial_lvl: assert property (@(posedge pclk) disable iff (!presetn)
		(int_req && int_level == 3'd5) |-> !$past(r_ff.flag[F_NMI]))
		else $error("level 5 beat nmi");
	a_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && !penable) |=> pready)
		else $error("no pready");
	c_nmi_taken: cover property (@(posedge pclk) disable iff (!presetn)
		int_req && int_level == 3'd0 ##1 ack_ev);
	c_timer_req: cover property (@(posedge pclk) disable iff (!presetn)
		int_req && int_vector == VEC_L1);
	c_serial_req: cover property (@(posedge pclk) disable iff (!presetn)
		int_req && int_vector == VEC_L5);
	c_edge_req: cover property (@(posedge pclk) disable iff (!presetn)
		int_req && int_vector == VEC_L2);
	c_pair_pending: cover property (@(posedge pclk) disable iff (!presetn)
		r_ff.flag[F_T0] && r_ff.flag[F_T1] && int_req);

	// Handshake with the CPU side
	a_ack_drops_req: assert property (@(posedge pclk)
		disable iff (!presetn)
		ack_ev |=> !int_req)
		else $error("request held after ack");
	a_ack_dead: assert property (@(posedge pclk)
		disable iff (!presetn)
		(r_ff.st == ST_ACK) |-> !int_req)
		else $error("request during dead cycle");
	// Only the nmi latch is cleared by the CPU; a new edge still wins
	a_nmi_ack_clear: assert property (@(posedge pclk)
		disable iff (!presetn)
		(ack_ev && r_ff.lvl == 3'd0 && !set_v[F_NMI])
		|=> !r_ff.flag[F_NMI])
		else $error("nmi flag kept after ack");
	a_disabled_quiet: assert property (@(posedge pclk)
		disable iff (!presetn)
		(r_ff.st == ST_IDLE && !r_ff.enable && !r_ff.flag[F_NMI])
		|=> !int_req)
		else $error("request while disabled");

	// Each shared level wins once everything above it is quiet
	a_timer_group: assert property (@(posedge pclk)
		disable iff (!presetn)
		(r_ff.st == ST_IDLE && !int_ack && !lvl_pend[0] && r_ff.enable
		&& r_ff.flag[F_T0] && !r_ff.mask[F_T0])
		|=> int_req && int_level == 3'd1)
		else $error("timer match not at level 1");
	a_rise_group: assert property (@(posedge pclk)
		disable iff (!presetn)
		(r_ff.st == ST_IDLE && !int_ack && lvl_pend[1:0] == 2'b00
		&& r_ff.enable && r_ff.flag[F_RISE] && !r_ff.mask[F_RISE])
		|=> int_req && int_level == 3'd2)
		else $error("rising request not at level 2");
	a_fall_group: assert property (@(posedge pclk)
		disable iff (!presetn)
		(r_ff.st == ST_IDLE && !int_ack && lvl_pend[1:0] == 2'b00
		&& r_ff.enable && r_ff.flag[F_FALL] && !r_ff.mask[F_FALL])
		|=> int_req && int_level == 3'd2)
		else $error("falling request not at level 2");
	a_counter_group: assert property (@(posedge pclk)
		disable iff (!presetn)
		(r_ff.st == ST_IDLE && !int_ack && lvl_pend[2:0] == 3'b000
		&& r_ff.enable && r_ff.flag[F_E1] && !r_ff.mask[F_E1])
		|=> int_req && int_level == 3'd3)
		else $error("counter match not at level 3");
	a_mixed_group: assert property (@(posedge pclk)
		disable iff (!presetn)
		(r_ff.st == ST_IDLE && !int_ack && lvl_pend[3:0] == 4'h0
		&& r_ff.enable && r_ff.flag[F_AD] && !r_ff.mask[F_AD])
		|=> int_req && int_level == 3'd4)
		else $error("conversion not at level 4");
	a_serial_group: assert property (@(posedge pclk)
		disable iff (!presetn)
		(r_ff.st == ST_IDLE && !int_ack && lvl_pend[4:0] == 5'h00
		&& r_ff.enable && r_ff.flag[F_SR] && !r_ff.mask[F_SR])
		|=> int_req && int_level == 3'd5)
		else $error("serial receive not at level 5");

	// Register side
	a_irq_level: assert property (@(posedge pclk)
		disable iff (!presetn)
		irq == |(r_ff.istat & ~r_ff.imask))
		else $error("irq out of step with status");
	a_flag_w1c: assert property (@(posedge pclk)
		disable iff (!presetn)
		(wr && paddr == A_FLAG && pwdata[F_T1] && !timer1_match)
		|=> !r_ff.flag[F_T1])
		else $error("flag not cleared by write");
	// A one-cycle ready keeps the access phase wait-free
	a_ready_pulse: assert property (@(posedge pclk)
		disable iff (!presetn)
		pready |=> !pready)
		else $error("ready held too long");
endmodule

/* File: tb/piu_cpu_model.sv */
/*
 * CPU side model: takes each request with int_ack after a delay and
 * records the vector and level it was given.
 * Assumes int_req stays up until the edge that sees int_ack.
 */
module piu_cpu_model #(
	parameter int ACK_DELAY = 2
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic int_req,
	input wire logic [7:0] int_vector,
	input wire logic [2:0] int_level,
	output logic int_ack,
	output logic [7:0] took_vec,
	output logic [2:0] took_lvl,
	output int took_cnt
);
	timeunit 1ns;
	timeprecision 1ns;
	int dly;
	// Slow ack keeps int_req standing for a few cycles
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_ack <= 1'h0;
			took_vec <= 8'h00;
			took_lvl <= 3'h7;
			took_cnt <= 0;
			dly <= 0;
		end else if (int_ack) begin
			int_ack <= 1'h0;
		end else if (int_req && dly < ACK_DELAY) begin
			dly <= dly + 1;
		end else if (int_req) begin
			int_ack <= 1'h1;
			took_vec <= int_vector;
			took_lvl <= int_level;
			took_cnt <= took_cnt + 1;
			dly <= 0;
		end
	end
endmodule

/* File: tb/testbench.sv */
/*
 * Self-checking bench for the interrupt unit: one row per flag source.
 * Assumes the CPU model on the request side and APB on the registers.
 */
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import piu_pkg::*;
	logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
	logic pwrite = 1'h0, pready, pslverr, int_ack, int_req, irq, er;
	logic [7:0] paddr = 8'h00, int_vector, took_vec;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [2:0] int_level, took_lvl;
	// Bit i drives the source of flag bit i; the nmi, falling and analog pins idle high and invert it
	logic [17:0] ev = 18'h0;
	int took_cnt, fails = 0, compares = 0, c;
	localparam logic [2:0] LV [18] = '{3'h0, 3'h1, 3'h1,
		3'h2, 3'h2, 3'h3, 3'h3, 3'h4, 3'h4,
		3'h5, 3'h5, 3'h7, 3'h7, 3'h7, 3'h7, 3'h7, 3'h7, 3'h7};
	localparam logic [7:0] VT [18] = '{VEC_L0, VEC_L1, VEC_L1, VEC_L2,
		VEC_L2, VEC_L3, VEC_L3, VEC_L4, VEC_L4, VEC_L5, VEC_L5, VEC_NONE,
		VEC_NONE, VEC_NONE, VEC_NONE, VEC_NONE, VEC_NONE, VEC_NONE};
	always #20 pclk = ~pclk;
	piu_core dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .nmi_n_pin(!ev[0]),
		.rising_edge_request(ev[3]), .falling_edge_request(!ev[4]),
		.upper_analog_pin(~ev[16:13]), .timer0_match(ev[1]),
		.timer1_match(ev[2]), .event_counter_match0(ev[5]),
		.event_counter_match1(ev[6]), .counter_input_fall(ev[7]),
		.conversion_done(ev[8]), .serial_rx_done(ev[9]),
		.serial_tx_done(ev[10]), .serial_error(ev[11]),
		.timer_overflow(ev[12]), .standby_entry(ev[17]),
		.int_ack(int_ack), .int_req(int_req), .int_vector(int_vector),
		.int_level(int_level), .irq(irq));
	piu_cpu_model #(.ACK_DELAY(2)) cpu_u (.pclk(pclk), .presetn(presetn),
		.int_req(int_req), .int_vector(int_vector), .int_level(int_level),
		.int_ack(int_ack), .took_vec(took_vec), .took_lvl(took_lvl),
		.took_cnt(took_cnt));
	task automatic complete_run();
		$display("fails %0d compares %0d", fails, compares);
		if (fails == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		compares++;
		if (g !== e) begin
			fails++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'h1 && n < 20);
		// Taken at the edge that samples pready high
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		if (n >= 20) begin
			fails++;
			complete_run();
		end
	endtask
	// Waits for a new take, and for vector v unless v is zero
	task automatic take(input logic [7:0] v);
		int n;
		n = 0;
		c = took_cnt;
		while ((took_cnt == c || (v != 8'h0 && took_vec !== v)) && n < 60) begin
			@(negedge pclk);
			n++;
		end
		if (n >= 60) begin
			fails++;
			complete_run();
		end
	endtask
	task automatic pulse(input logic [17:0] m);
		ev <= m;
		@(posedge pclk);
		ev <= 18'h0;
	endtask
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'h1;
		apb(1'h0, A_MASK, 32'h0);
		chk("mask reset", 32'h7fe, rd);
		apb(1'h0, A_FLAG, 32'h0);
		chk("flag reset", 32'h0, rd);
		apb(1'h0, 8'hfc, 32'h0);
		chk("unmapped err", 32'h1, {31'h0, er});
		apb(1'h1, A_MASK, 32'h0);
		apb(1'h1, A_CTRL, 32'h1);
		apb(1'h1, A_IMASK, 32'h0);
		for (int i = 0; i < 18; i++) begin
			pulse(18'h1 << i);
			if (LV[i] != 3'h7) begin
				take(8'h0);
				chk("vector", VT[i], took_vec);
				chk("level", LV[i], took_lvl);
				chk("irq", 32'h1, irq);
			end else
				repeat (6) @(posedge pclk);
			apb(1'h0, A_FLAG, 32'h0);
			chk("flag", (LV[i] == 3'h0) ? 0 : (1 << i), rd);
			apb(1'h1, A_FLAG, 32'h1 << i);
			apb(1'h1, A_ISTAT, 32'h3);
			apb(1'h0, A_FLAG, 32'h0);
			@(negedge pclk);
			chk("flag clear", 32'h0, rd);
			chk("irq clear", 32'h0, irq);
		end
		apb(1'h1, A_MASK, 32'h2);
		apb(1'h1, A_IMASK, 32'h3);
		pulse(18'h6);
		take(8'h0);
		chk("unmasked vec", VEC_L1, took_vec);
		chk("irq masked", 32'h0, irq);
		apb(1'h1, A_FLAG, 32'h4);
		repeat (4) @(posedge pclk);
		c = took_cnt;
		repeat (10) @(posedge pclk);
		chk("masked take", c, took_cnt);
		apb(1'h1, A_FLAG, 32'h2);
		apb(1'h1, A_MASK, 32'h0);
		apb(1'h1, A_CTRL, 32'h0);
		pulse(18'h404);
		apb(1'h1, A_CTRL, 32'h1);
		take(8'h0);
		chk("first level", VEC_L1, took_vec);
		apb(1'h1, A_FLAG, 32'h4);
		take(VEC_L5);
		chk("last level", VEC_L5, took_vec);
		complete_run();
	end
endmodule
